// File: bench/cbg_far_end.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Peripherals, memory, bus master and interrupt sources
// ----------------------------------------------------------------------
module cbg_far_end (
    // Controls from the bench
    input  wire        clk,
    input  wire        want_bus,
    input  wire        want_int,
    input  wire        want_nmi,
    input  wire [3:0]  stall,
    // Pins from the device
    input  wire [15:0] addr_out,
    input  wire [7:0]  data_out,
    input  wire        data_oe,
    input  wire        strobe_oe,
    input  wire        memory_request_n,
    input  wire        io_request_n,
    input  wire        read_n,
    input  wire        write_n,
    input  wire        opcode_fetch_indicator_n,
    // Pins to the device
    output wire        bus_request_n,
    output wire        int_request_n,
    output wire        nmi_request_n,
    output wire        wait_n,
    output wire [7:0]  data_in
);
    parameter [7:0] VECTOR = 8'h40;
    reg [7:0] mem [0:255];
    reg [7:0] last_reg = 8'h00;
    reg [3:0] cnt_reg = 4'h0;
    reg       seen_reg = 1'b0;
    integer   i;
    wire ack = strobe_oe && !io_request_n && !opcode_fetch_indicator_n;
    wire rd = strobe_oe && !memory_request_n && !read_n;
    // Wait is raised in the acknowledge's first state, early enough to
    // pass the device's synchroniser before the automatic waits end.
    wire ack_t1 = strobe_oe && !opcode_fetch_indicator_n &&
                  memory_request_n && io_request_n && read_n;

    initial begin
        for (i = 0; i < 256; i = i + 1)
            mem[i] = i[7:0] ^ 8'h5a;
    end
    // A released data bus must not keep showing its last byte.
    assign data_in = ack ? VECTOR : rd ? mem[addr_out[7:0]] : ~last_reg;
    assign bus_request_n = ~want_bus;
    assign int_request_n = ~want_int;
    assign nmi_request_n = ~want_nmi;
    assign wait_n = (cnt_reg == 4'h0);

    always @(posedge clk) begin
        last_reg <= data_in;
        seen_reg <= ack_t1;
        if (ack_t1 && !seen_reg)
            cnt_reg <= stall;
        else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
        if (strobe_oe && data_oe && !memory_request_n && !write_n)
            mem[addr_out[7:0]] <= data_out;
    end
endmodule // cbg_far_end

// File: bench/cbg_seq_sva.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Checker on the sequencer's pins
// ----------------------------------------------------------------------
module cbg_seq_sva (
    // Clock, reset and register writes
    input wire        clk,
    input wire        nrst,
    input wire [3:0]  avs_address,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire        avs_waitrequest,
    // System bus pins
    input wire        bus_request_n,
    input wire [15:0] addr_out,
    input wire        addr_oe,
    input wire        data_oe,
    input wire        strobe_oe,
    input wire        memory_request_n,
    input wire        io_request_n,
    input wire        read_n,
    input wire        opcode_fetch_indicator_n,
    input wire        refresh_strobe_n,
    input wire        halt_n,
    input wire        bus_grant_n,
    // Sequencer side
    input wire        seq_halt_fetch,
    input wire        seq_hold,
    input wire        seq_pc_load,
    input wire [15:0] seq_pc_value
);
    // Shadow of the vector page, so refresh addresses can be judged.
    reg [7:0] page_reg;

    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            page_reg <= 8'h00;
        else if (avs_write && !avs_waitrequest && avs_address == 4'h0)
            page_reg <= avs_writedata[15:8];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_grant_floats: assert property (!bus_grant_n |->
        !addr_oe && !strobe_oe && !data_oe) else $error("bus driven in grant");
    a_grant_no_refresh: assert property (!bus_grant_n |->
        refresh_strobe_n) else $error("refresh during grant");
    a_float_needs_grant: assert property (!addr_oe |->
        !bus_grant_n) else $error("address floated without grant");
    a_grant_cause: assert property ($fell(bus_grant_n) |->
        !$past(bus_request_n, 2)) else $error("grant without request");
    a_grant_release: assert property
        ($rose(bus_request_n) && !bus_grant_n |-> ##[1:5] bus_grant_n)
        else $error("grant not returned");
    a_no_irq_float: assert property (!bus_grant_n |->
        !seq_pc_load) else $error("interrupt taken while floated");
    a_inta_no_memory_request_n: assert property
        (strobe_oe && !io_request_n && !opcode_fetch_indicator_n |->
        memory_request_n && read_n) else $error("memory strobes in ack");
    a_inta_two_waits: assert property
        ($fell(io_request_n) && !opcode_fetch_indicator_n |->
        !io_request_n ##1 !io_request_n) else $error("ack waits short");
    a_refresh_addr: assert property (!refresh_strobe_n && addr_oe |->
        addr_out[15:8] == page_reg) else $error("refresh page wrong");
    a_halt_entry: assert property (seq_halt_fetch |=>
        ##[0:2] !halt_n) else $error("halt indicator late");
    a_reset_dummy: assert property ($rose(nrst) |-> seq_hold [*2]
        ##[1:6] (seq_pc_load && seq_pc_value == 16'h0000))
        else $error("reset start wrong");

    c_grant: cover property (!bus_grant_n);
    c_ack: cover property (!io_request_n && !opcode_fetch_indicator_n);
    c_halt: cover property (!halt_n);
endmodule // cbg_seq_sva

bind cbg_seq cbg_seq_sva i_sva (.clk, .nrst, .avs_address, .avs_write,
    .avs_writedata, .avs_waitrequest, .bus_request_n, .addr_out, .addr_oe,
    .data_oe, .strobe_oe, .memory_request_n, .io_request_n, .read_n,
    .opcode_fetch_indicator_n, .refresh_strobe_n, .halt_n, .bus_grant_n,
    .seq_halt_fetch, .seq_hold, .seq_pc_load, .seq_pc_value);

// File: bench/cbg_seq_test.sv
`timescale 1ns/1ns
module cbg_seq_test;
    reg         clk = 1'b0, nrst = 1'b0;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'b0, avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, bus_request_n, int_request_n, nmi_request_n;
    wire        wait_n, addr_oe, data_oe, memory_request_n, io_request_n;
    wire        read_n, write_n, strobe_oe, opcode_fetch_indicator_n;
    wire        refresh_strobe_n, halt_n, bus_grant_n, seq_hold;
    wire        seq_pc_load;
    wire [7:0]  data_in, data_out;
    wire [15:0] addr_out, seq_pc_value, seq_sp_value;
    reg  [15:0] seq_addr = 16'h0000, seq_pc = 16'h1234;
    reg         seq_memory_request_n_n = 1'b1, seq_rd_n = 1'b1, seq_m1_n = 1'b1;
    reg         seq_refresh_strobe_n_n = 1'b1, seq_cycle_end = 1'b0, seq_instr_end = 1'b0;
    reg         seq_halt_fetch = 1'b0;
    reg         want_bus = 1'b0, want_int = 1'b0, want_nmi = 1'b0;
    reg  [3:0]  stall = 4'h0;
    reg  [31:0] rdata, pcv;
    integer     fails = 0, comparisons = 0, cyc, n;

    cbg_seq i_dut (.clk, .nrst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .bus_request_n,
        .int_request_n, .nmi_request_n, .wait_n, .data_in, .addr_out,
        .addr_oe, .data_out, .data_oe, .memory_request_n, .io_request_n,
        .read_n, .write_n, .strobe_oe, .opcode_fetch_indicator_n,
        .refresh_strobe_n, .halt_n, .bus_grant_n, .seq_addr,
        .seq_dout(8'h00), .seq_dout_en(1'b0), .seq_memory_request_n_n,
        .seq_io_request_n_n(1'b1), .seq_rd_n, .seq_wr_n(1'b1), .seq_m1_n,
        .seq_refresh_strobe_n_n, .seq_cycle_end, .seq_instr_end, .seq_halt_fetch,
        .seq_pc, .seq_sp(16'hff00), .seq_hold, .seq_pc_load, .seq_pc_value,
        .seq_sp_load(), .seq_sp_value);
    cbg_far_end i_far (.clk, .want_bus, .want_int, .want_nmi, .stall,
        .addr_out, .data_out, .data_oe, .strobe_oe, .memory_request_n,
        .io_request_n, .read_n, .write_n, .opcode_fetch_indicator_n,
        .bus_request_n, .int_request_n, .nmi_request_n, .wait_n, .data_in);

    initial begin
        forever #20 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task chk(input [8*12:1] what, input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task av(input [3:0] a, input wr, input [31:0] wd);
        integer k;
        begin
            @(posedge clk);
            avs_address <= a;
            avs_write <= wr;
            avs_read <= !wr;
            avs_writedata <= wd;
            k = 0;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0 && k < 50) begin
                @(posedge clk);
                k = k + 1;
            end
            rdata = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
        end
    endtask
    task pulse_end(input instr);
        begin
            @(posedge clk);
            seq_cycle_end <= 1'b1;
            seq_instr_end <= instr;
            @(posedge clk);
            seq_cycle_end <= 1'b0;
            seq_instr_end <= 1'b0;
        end
    endtask
    // The answer is a one-cycle pulse, so it is sampled on every edge.
    task wait_pc;
        begin
            pcv = 32'hffffffff;
            for (cyc = 0; cyc < 300 && pcv == 32'hffffffff; cyc = cyc + 1) begin
                @(posedge clk);
                if (seq_pc_load === 1'b1)
                    pcv = {16'h0000, seq_pc_value};
            end
        end
    endtask
    task complete_run;
        begin
            $display("comparisons %0d fails %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        #400000;
        fails = fails + 1;
        complete_run;
    end
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        wait_pc;
        chk("boot_pc", 32'h0, pcv);
        chk("dummy", 32'h1, {31'h0, cyc >= 2});
        av(4'h0, 1'b0, 32'h0);
        chk("ctrl_rst", 32'h0, rdata);
        av(4'hc, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rdata);
        seq_addr <= 16'h2345;
        seq_memory_request_n_n <= 1'b0;
        seq_rd_n <= 1'b0;
        seq_m1_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("run_addr", 32'h2345, {16'h0, addr_out});
        seq_memory_request_n_n <= 1'b1;
        seq_rd_n <= 1'b1;
        seq_m1_n <= 1'b1;
        want_int <= 1'b1;
        repeat (3) @(posedge clk);
        pulse_end(1'b1);
        wait_pc;
        chk("masked", 32'hffffffff, pcv);
        want_int <= 1'b0;
        $display("test reset and masking done");
        want_bus <= 1'b1;
        repeat (3) @(posedge clk);
        pulse_end(1'b0);
        for (n = 0; n < 50 && bus_grant_n !== 1'b0; n = n + 1)
            @(posedge clk);
        chk("grant", 32'h0, {31'h0, bus_grant_n});
        chk("float", 32'h0, {29'h0, addr_oe, strobe_oe, data_oe});
        chk("refresh_strobe_n_high", 32'h1, {31'h0, refresh_strobe_n});
        want_nmi <= 1'b1;
        repeat (3) @(posedge clk);
        pulse_end(1'b1);
        av(4'h4, 1'b0, 32'h0);
        chk("status", 32'h5, rdata & 32'h7);
        want_bus <= 1'b0;
        for (n = 0; n < 50 && bus_grant_n !== 1'b1; n = n + 1)
            @(posedge clk);
        chk("released", 32'h1, {31'h0, bus_grant_n});
        seq_pc <= 16'h2468;
        pulse_end(1'b1);
        wait_pc;
        chk("nmi_pc", 32'h0066, pcv);
        chk("nmi_push", 32'h2468, {16'h0, i_far.mem[255], i_far.mem[254]});
        chk("nmi_sp", 32'hfefe, {16'h0, seq_sp_value});
        want_nmi <= 1'b0;
        $display("test grant and nmi done");
        av(4'h0, 1'b1, 32'h00001201);
        seq_pc <= 16'h1234;
        stall <= 4'h3;
        want_int <= 1'b1;
        repeat (3) @(posedge clk);
        pulse_end(1'b1);
        wait_pc;
        want_int <= 1'b0;
        chk("int_pc", 32'h1b1a, pcv);
        chk("int_push", 32'h1234, {16'h0, i_far.mem[255], i_far.mem[254]});
        av(4'h0, 1'b0, 32'h0);
        chk("ie_clear", 32'h1200, rdata);
        $display("test maskable interrupt done");
        @(posedge clk);
        seq_halt_fetch <= 1'b1;
        @(posedge clk);
        seq_halt_fetch <= 1'b0;
        for (n = 0; n < 50 && halt_n !== 1'b0; n = n + 1)
            @(posedge clk);
        chk("halted", 32'h0, {31'h0, halt_n});
        pulse_end(1'b1);
        cyc = 0;
        for (n = 0; n < 40; n = n + 1) begin
            @(posedge clk);
            if (refresh_strobe_n === 1'b0)
                cyc = cyc + 1;
        end
        chk("nop_refresh_strobe_n", 32'h1, {31'h0, cyc > 0});
        want_nmi <= 1'b1;
        wait_pc;
        chk("wake_pc", 32'h0066, pcv);
        chk("halt_off", 32'h1, {31'h0, halt_n});
        $display("test halt done");
        complete_run;
    end
endmodule // cbg_seq_test

// File: rtl/cbg_regs.vh
`ifndef CBG_REGS_VH
`define CBG_REGS_VH

// ----------------------------------------------------------------------
// Register map, byte addresses on the Avalon-MM slave
// ----------------------------------------------------------------------
`define CBG_OFS_CTRL      4'h0
`define CBG_OFS_STATUS    4'h4
`define CBG_OFS_REFRESH   4'h8

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CBG_CTRL_IE_BIT   0
`define CBG_CTRL_PAGE_LSB 8
`define CBG_STAT_GRANT    0
`define CBG_STAT_HALT     1
`define CBG_STAT_NMI      2
`define CBG_STAT_ST_LSB   8
`define CBG_RST_IE        1'h0
`define CBG_RST_PAGE      8'h00

// ----------------------------------------------------------------------
// Addresses and timing counts
// ----------------------------------------------------------------------
`define CBG_NMI_VECTOR    16'h0066
`define CBG_RESET_VECTOR  16'h0000
`define CBG_DUMMY_STATES  2'h2

`endif

// File: rtl/cbg_seq.v
`timescale 1ns/1ns
// What this block does
// - Sample bus request at each machine cycle end; float from next edge.
// - While granted, address, data and bus strobes go high impedance.
// - Resample bus request every float state; high resumes the cycle.
// - Bus grant output stays low for the whole float.
// - No refresh during a grant; refresh strobe held high.
// - No maskable or non-maskable interrupt accepted while floated.
// - Maskable request taken at instruction end if enabled, bus not requested.
// - Acknowledge fetch adds two automatic waits; wait low extends it further.
// - Acknowledge asserts I/O request with fetch indicator; vector read in.
// - Acknowledge T3 drives refresh address and refresh strobe.
// - Push PC in M2, M3; load PC from page:vector table in M4, M5.
// - Non-maskable falling edge sets pending flag, checked at instruction end.
// - Non-maskable fetch discards byte, pushes PC, continues at 0066H.
// - Halt fetch drives halt indicator low at T4, then stops execution.
// - Halted: keep issuing no-operation fetches with refresh, ignore data.
// - Halt left on reset or interrupt sampled at each no-operation T4.
// - After reset, a two-state dummy cycle, then execution at 0000H.
// - Refresh address is vector page high and refresh counter low.
`include "cbg_regs.vh"

module cbg_seq (
    // Clock and reset
    input  wire        clk,
    input  wire        nrst,
    // Avalon-MM register slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // System bus pins, asynchronous inputs
    input  wire        bus_request_n,
    input  wire        int_request_n,
    input  wire        nmi_request_n,
    input  wire        wait_n,
    input  wire [7:0]  data_in,
    // System bus pins, outputs with enables
    output reg  [15:0] addr_out,
    output reg         addr_oe,
    output reg  [7:0]  data_out,
    output reg         data_oe,
    output reg         memory_request_n,
    output reg         io_request_n,
    output reg         read_n,
    output reg         write_n,
    output reg         strobe_oe,
    output reg         opcode_fetch_indicator_n,
    output reg         refresh_strobe_n,
    output reg         halt_n,
    output reg         bus_grant_n,
    // Instruction sequencer side, same clock
    input  wire [15:0] seq_addr,
    input  wire [7:0]  seq_dout,
    input  wire        seq_dout_en,
    input  wire        seq_memory_request_n_n,
    input  wire        seq_io_request_n_n,
    input  wire        seq_rd_n,
    input  wire        seq_wr_n,
    input  wire        seq_m1_n,
    input  wire        seq_refresh_strobe_n_n,
    input  wire        seq_cycle_end,
    input  wire        seq_instr_end,
    input  wire        seq_halt_fetch,
    input  wire [15:0] seq_pc,
    input  wire [15:0] seq_sp,
    output reg         seq_hold,
    output reg         seq_pc_load,
    output reg  [15:0] seq_pc_value,
    output reg         seq_sp_load,
    output reg  [15:0] seq_sp_value
);

// ----------------------------------------------------------------------
// States and kinds of special cycle
// ----------------------------------------------------------------------
localparam [3:0] S_RUN = 4'h0, S_FLOAT = 4'h1, S_DUMMY = 4'h2,
                 S_FT1 = 4'h3, S_FT2 = 4'h4, S_FW1 = 4'h5, S_FW2 = 4'h6,
                 S_FTW = 4'h7, S_FT3 = 4'h8, S_FT4 = 4'h9,
                 S_MT1 = 4'ha, S_MT2 = 4'hb, S_MT3 = 4'hc;
localparam [1:0] K_INTA = 2'h0, K_NMI = 2'h1, K_HALT = 2'h2;

// ----------------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------------
reg  [11:0] sync1_reg;
reg  [11:0] sync2_reg;
reg         nmi_d_reg;
wire        bus_request_n_s = sync2_reg[11];
wire        int_s    = sync2_reg[10];
wire        nmi_s    = sync2_reg[9];
wire        wait_s   = sync2_reg[8];
wire [7:0]  data_s   = sync2_reg[7:0];

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        sync1_reg <= 12'hfff;
        sync2_reg <= 12'hfff;
        nmi_d_reg <= 1'b1;
    end else begin
        sync1_reg <= {bus_request_n, int_request_n, nmi_request_n, wait_n,
                      data_in};
        sync2_reg <= sync1_reg;
        nmi_d_reg <= nmi_s;
    end
end

// ----------------------------------------------------------------------
// State registers
// ----------------------------------------------------------------------
reg  [3:0]  st_reg, st_next, ret_reg, ret_next;
reg  [1:0]  kind_reg, kind_next;
reg  [2:0]  mc_reg, mc_next;
reg  [1:0]  dcnt_reg;
reg  [15:0] pc_reg, sp_reg;
reg  [7:0]  vec_reg, pcl_reg, rcnt_reg, page_reg;
reg         ie_reg, nmi_pend_reg, halt_pend_reg;
reg         cyc_end, ld_pc, tk_any;
reg  [3:0]  after;

wire want_nmi = nmi_pend_reg && bus_request_n_s;
wire want_int = !int_s && ie_reg && bus_request_n_s && !want_nmi;

always @* begin
    after     = st_reg;
    ret_next  = ret_reg;
    kind_next = kind_reg;
    mc_next   = mc_reg;
    cyc_end   = 1'b0;
    ld_pc     = 1'b0;
    tk_any    = 1'b0;
    case (st_reg)
        S_DUMMY: begin
            if (dcnt_reg == `CBG_DUMMY_STATES - 2'h1) begin
                after = S_RUN;
                ld_pc = 1'b1;
            end
        end
        S_RUN: begin
            if (seq_cycle_end) begin
                cyc_end = 1'b1;
                if (seq_instr_end) begin
                    if (want_nmi || want_int) begin
                        tk_any    = 1'b1;
                        after     = S_FT1;
                        kind_next = want_nmi ? K_NMI : K_INTA;
                    end else if (halt_pend_reg) begin
                        after     = S_FT1;
                        kind_next = K_HALT;
                    end
                end
            end
        end
        S_FLOAT: begin
            if (bus_request_n_s)
                after = ret_reg;
        end
        S_FT1: after = S_FT2;
        S_FT2: begin
            if (kind_reg == K_INTA)
                after = S_FW1;
            else
                after = wait_s ? S_FT3 : S_FTW;
        end
        S_FW1: after = S_FW2;
        S_FW2: after = wait_s ? S_FT3 : S_FTW;
        S_FTW: after = wait_s ? S_FT3 : S_FTW;
        S_FT3: after = S_FT4;
        S_FT4: begin
            cyc_end = 1'b1;
            if (kind_reg != K_HALT) begin
                after   = S_MT1;
                mc_next = 3'h2;
            end else if (want_nmi || want_int) begin
                tk_any    = 1'b1;
                after     = S_FT1;
                kind_next = want_nmi ? K_NMI : K_INTA;
            end else begin
                after = S_FT1;
            end
        end
        S_MT1: after = S_MT2;
        S_MT2: after = wait_s ? S_MT3 : S_MT2;
        S_MT3: begin
            cyc_end = 1'b1;
            if ((mc_reg == 3'h3 && kind_reg == K_NMI) ||
                mc_reg == 3'h5) begin
                after = S_RUN;
                ld_pc = 1'b1;
            end else begin
                after   = S_MT1;
                mc_next = mc_reg + 3'h1;
            end
        end
        default: after = S_RUN;
    endcase
    st_next = after;
    if (cyc_end && !bus_request_n_s) begin
        st_next  = S_FLOAT;
        ret_next = after;
    end
end

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        st_reg        <= S_DUMMY;
        ret_reg       <= S_RUN;
        kind_reg      <= K_HALT;
        mc_reg        <= 3'h2;
        dcnt_reg      <= 2'h0;
        pc_reg        <= 16'h0000;
        sp_reg        <= 16'h0000;
        vec_reg       <= 8'h00;
        pcl_reg       <= 8'h00;
        rcnt_reg      <= 8'h00;
        nmi_pend_reg  <= 1'b0;
        halt_pend_reg <= 1'b0;
    end else begin
        st_reg   <= st_next;
        ret_reg  <= ret_next;
        kind_reg <= kind_next;
        mc_reg   <= mc_next;
        dcnt_reg <= (st_reg == S_DUMMY) ? dcnt_reg + 2'h1 : 2'h0;
        if (tk_any && st_reg == S_RUN) begin
            pc_reg <= seq_pc;
            sp_reg <= seq_sp;
        end
        // The synchroniser delays the bus by two edges, so the vector
        // is taken as T3 ends, when it shows the next-to-last wait state's byte.
        if (kind_reg == K_INTA && st_reg == S_FT3)
            vec_reg <= data_s;
        if (st_reg == S_MT3 && mc_reg == 3'h4)
            pcl_reg <= data_s;
        if (st_reg == S_FT3)
            rcnt_reg <= {rcnt_reg[7], rcnt_reg[6:0] + 7'h01};
        // A new edge in the acceptance cycle keeps the flag set.
        if (nmi_d_reg && !nmi_s)
            nmi_pend_reg <= 1'b1;
        else if (tk_any && kind_next == K_NMI)
            nmi_pend_reg <= 1'b0;
        if (seq_halt_fetch)
            halt_pend_reg <= 1'b1;
        else if (kind_next == K_HALT && st_next == S_FT1)
            halt_pend_reg <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// Bus drive, decoded from the next state
// ----------------------------------------------------------------------
reg  [15:0] o_a;
reg  [7:0]  o_d;
reg         o_aoe, o_doe, o_soe, o_memory_request_n, o_io_request_n, o_rd, o_wr, o_m1;
reg         o_refresh_strobe_n, o_grant;
wire [15:0] pcsel = (st_reg == S_RUN) ? seq_pc : pc_reg;
wire        inta  = (kind_next == K_INTA);

always @* begin
    o_a = seq_addr; o_d = seq_dout; o_aoe = 1'b1; o_doe = seq_dout_en;
    o_soe = 1'b1; o_memory_request_n = seq_memory_request_n_n; o_io_request_n = seq_io_request_n_n;
    o_rd = seq_rd_n; o_wr = seq_wr_n; o_m1 = seq_m1_n;
    o_refresh_strobe_n = seq_refresh_strobe_n_n; o_grant = 1'b1;
    if (st_next != S_RUN) begin
        o_a = pcsel; o_d = 8'h00; o_doe = 1'b0; o_memory_request_n = 1'b1;
        o_io_request_n = 1'b1; o_rd = 1'b1; o_wr = 1'b1; o_m1 = 1'b1;
        o_refresh_strobe_n = 1'b1;
    end
    case (st_next)
        S_FLOAT: begin
            o_aoe = 1'b0; o_soe = 1'b0;
            o_grant = 1'b0;
        end
        S_DUMMY: o_a = `CBG_RESET_VECTOR;
        S_FT1, S_FT2: begin
            o_m1 = 1'b0; o_memory_request_n = inta; o_rd = inta;
        end
        S_FW1, S_FW2: begin
            o_m1 = 1'b0; o_io_request_n = 1'b0;
        end
        S_FTW: begin
            o_m1 = 1'b0; o_io_request_n = !inta; o_memory_request_n = inta; o_rd = inta;
            if (inta)
                o_io_request_n = 1'b0;
        end
        S_FT3, S_FT4: begin
            o_a = {page_reg, rcnt_reg};
            o_refresh_strobe_n = 1'b0;
            o_memory_request_n = (st_next == S_FT4);
        end
        S_MT1, S_MT2, S_MT3: begin
            o_memory_request_n = 1'b0;
            if (mc_next <= 3'h3) begin
                o_a = sp_reg - ((mc_next == 3'h2) ? 16'h0001 : 16'h0002);
                o_d = (mc_next == 3'h2) ? pc_reg[15:8] : pc_reg[7:0];
                o_doe = 1'b1;
                o_wr = (st_next != S_MT2);
            end else begin
                o_a = {page_reg, vec_reg} + {15'h0000, mc_next == 3'h5};
                o_rd = 1'b0;
            end
        end
        default: o_grant = 1'b1;
    endcase
end

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        addr_out <= 16'h0000; addr_oe <= 1'b1;
        data_out <= 8'h00; data_oe <= 1'b0; strobe_oe <= 1'b1;
        memory_request_n <= 1'b1; io_request_n <= 1'b1;
        read_n <= 1'b1; write_n <= 1'b1;
        opcode_fetch_indicator_n <= 1'b1; refresh_strobe_n <= 1'b1;
        bus_grant_n <= 1'b1; halt_n <= 1'b1; seq_hold <= 1'b1;
        seq_pc_load <= 1'b0; seq_pc_value <= 16'h0000;
        seq_sp_load <= 1'b0; seq_sp_value <= 16'h0000;
    end else begin
        addr_out <= o_a; addr_oe <= o_aoe;
        data_out <= o_d; data_oe <= o_doe; strobe_oe <= o_soe;
        memory_request_n <= o_memory_request_n; io_request_n <= o_io_request_n;
        read_n <= o_rd; write_n <= o_wr;
        opcode_fetch_indicator_n <= o_m1;
        refresh_strobe_n <= o_refresh_strobe_n;
        bus_grant_n <= o_grant;
        seq_hold <= (st_next != S_RUN);
        if (seq_halt_fetch)
            halt_n <= 1'b0;
        else if (tk_any && kind_reg == K_HALT && st_reg == S_FT4)
            halt_n <= 1'b1;
        seq_pc_load <= ld_pc;
        seq_sp_load <= ld_pc && (st_reg == S_MT3);
        seq_sp_value <= sp_reg - 16'h0002;
        if (st_reg == S_DUMMY)
            seq_pc_value <= `CBG_RESET_VECTOR;
        else if (kind_reg == K_NMI)
            seq_pc_value <= `CBG_NMI_VECTOR;
        else
            seq_pc_value <= {data_s, pcl_reg};
    end
end

// ----------------------------------------------------------------------
// Avalon-MM slave, one wait state per access
// ----------------------------------------------------------------------
wire acc = avs_read || avs_write;
wire wr_hit = avs_write && !avs_waitrequest &&
              avs_address == `CBG_OFS_CTRL;

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        avs_waitrequest <= 1'b1;
        avs_readdata    <= 32'h00000000;
        ie_reg          <= `CBG_RST_IE;
        page_reg        <= `CBG_RST_PAGE;
    end else begin
        avs_waitrequest <= !(acc && avs_waitrequest);
        // Software enabling wins over the clear made by acceptance.
        if (wr_hit) begin
            ie_reg   <= avs_writedata[`CBG_CTRL_IE_BIT];
            page_reg <= avs_writedata[`CBG_CTRL_PAGE_LSB +: 8];
        end else if (tk_any) begin
            ie_reg <= 1'b0;
        end
        if (avs_read && avs_waitrequest) begin
            case (avs_address)
                `CBG_OFS_CTRL:
                    avs_readdata <= {16'h0000, page_reg, 7'h00, ie_reg};
                `CBG_OFS_STATUS:
                    avs_readdata <= {20'h00000, st_reg, 5'h00,
                                     nmi_pend_reg, !halt_n, !bus_grant_n};
                `CBG_OFS_REFRESH:
                    avs_readdata <= {24'h000000, rcnt_reg};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end
end

endmodule // cbg_seq
